// file: design/bpf_regs.svh
// Summary of operation
// - Cell and sense pin inside all limits: charge and discharge switches both on.
// - Normal status: sense pull-up and pull-down resistors both disconnected.
// - Cell above overcharge level for detect delay: charge off, resistors disconnected.
// - Overcharged, sense below discharge overcurrent: release below overcharge release level.
// - Overcharged, sense at/above discharge overcurrent: release below overcharge detect level.
// - Cell below overdischarge level for detect delay: discharge switch off.
// - Overdischarge: pull-up to supply connected, pull-down disconnected.
// - Power-down option: overdischarge returns to normal only through charger connection.
// - Charger seen on sense pin: release overdischarge once cell exceeds overdischarge level.
// - No charger on sense pin: no release before cell exceeds overdischarge level.
// - Auto-wake, no charger: release after cell holds release level beyond release delay.
// - Sense in discharge overcurrent band for its delay: discharge switch off.
// - Sense at/above short level for short delay: discharge switch off.
// - Discharge overcurrent or short status: pull-down connected, pull-up disconnected.
// - Discharge overcurrent or short status released when sense pin returns near ground.
// - Sense at/below charge overcurrent level for its delay: charge switch off.
// - Without 0V charge permission, charge path stays blocked for a 0V cell.
// - Charger voltage above overvoltage detect level: charge switch off.
// - Charger voltage below overvoltage release level: charge switch back on.
// - Charger overvoltage detect and release act at once, no delay timer.
// - Power-down option: sleep from overdischarge, leave only on charger connection.
// - Auto-wake option: stay active, return to normal above overdischarge release level.
// - Overcharge detect delay 1000 ms; overdischarge detect delay 115 ms.
// - Discharge and charge overcurrent detect delays each 10 ms.
// - Short detect delay 360 us.
// - All four release delays 2 ms each.
`ifndef BPF_REGS_SVH
`define BPF_REGS_SVH
`define BPF_CLK_HZ            25000000
`define BPF_OC_DET_MS         1000
`define BPF_OD_DET_MS         115
`define BPF_DOC_DET_MS        10
`define BPF_COC_DET_MS        10
`define BPF_SHORT_DET_US      360
`define BPF_RELEASE_MS        2
`define BPF_CTRL_OFS          8'h00
`define BPF_STATUS_OFS        8'h04
`define BPF_EVENT_OFS         8'h08
`define BPF_CTRL_PDN_BIT      0
`define BPF_CTRL_ZV_BIT       1
`define BPF_CTRL_RESET        2'h0
`define BPF_ST_CODE_LSB       0
`define BPF_ST_DRIVE_LSB      4
`define BPF_ST_CHGOV_BIT      9
`define BPF_EV_OVERCHARGE     0
`define BPF_EV_OVERDISCHARGE  1
`define BPF_EV_DSG_OC         2
`define BPF_EV_SHORT          3
`define BPF_EV_CHG_OC         4
`define BPF_EV_CHG_OV         5
`define BPF_EV_SLEEP          6
`define BPF_EVENT_RESET       7'h00
`define BPF_RESP_OKAY         2'h0
`define BPF_RESP_SLVERR       2'h2
`endif

// file: design/bpf_pkg.sv
package bpf_pkg;
	// Qualified comparator decisions, all asynchronous to aclk
	typedef struct packed {
		logic cell_over_charge;
		logic cell_under_charge_release;
		logic cell_under_discharge;
		logic cell_over_discharge_release;
		logic sense_over_discharge_current;
		logic sense_over_short;
		logic sense_under_charge_current;
		logic sense_charger_present;
		logic sense_near_ground;
		logic charger_over_voltage;
		logic charger_under_release;
		logic cell_at_zero_volt;
	} bpf_cmp_type;

	typedef struct packed {
		logic sleep;
		logic sense_pulldown_resistor_en;
		logic sense_pullup_resistor_en;
		logic dsg_switch_en;
		logic chg_switch_en;
	} bpf_drive_type;

	typedef enum logic [2:0] {
		BPF_NORMAL,
		BPF_OVERCHARGE,
		BPF_OVERDISCHARGE,
		BPF_SLEEP,
		BPF_DSG_OC,
		BPF_CHG_OC
	} bpf_state_type;
endpackage

// file: design/bpf_protect.sv
`include "bpf_regs.svh"

// Counts while run is high, restarts from zero as soon as run drops
module bpf_delay_timer
	import bpf_pkg::*;
#(
	parameter int unsigned LIMIT = 1
)
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic run,
	output logic      expired
);
	localparam logic [24:0] LIM = 25'(LIMIT);
	logic [24:0] count_ff;
	logic [24:0] nxt_count;

	assign nxt_count = !run ? 25'h0000000 : (count_ff == LIM) ? count_ff : count_ff + 25'h0000001;
	assign expired   = run && (count_ff == LIM);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_ff <= 25'h0000000;
		else
			count_ff <= nxt_count;
	end
endmodule

module bpf_protect
	import bpf_pkg::*;
#(
	parameter int unsigned OC_DET_CYC    = `BPF_OC_DET_MS * (`BPF_CLK_HZ / 1000),
	parameter int unsigned OD_DET_CYC    = `BPF_OD_DET_MS * (`BPF_CLK_HZ / 1000),
	parameter int unsigned DOC_DET_CYC   = `BPF_DOC_DET_MS * (`BPF_CLK_HZ / 1000),
	parameter int unsigned COC_DET_CYC   = `BPF_COC_DET_MS * (`BPF_CLK_HZ / 1000),
	parameter int unsigned SHORT_DET_CYC = `BPF_SHORT_DET_US * (`BPF_CLK_HZ / 1000000),
	parameter int unsigned RELEASE_CYC   = `BPF_RELEASE_MS * (`BPF_CLK_HZ / 1000)
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire bpf_cmp_type cmp,
	output bpf_drive_type    drive,
	input  wire logic [31:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [31:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready
);
	bpf_cmp_type   cmp_meta_ff;
	bpf_cmp_type   cs_ff;
	bpf_state_type state_ff;
	bpf_state_type nxt_state;
	bpf_drive_type drive_ff;
	bpf_drive_type nxt_drive;
	logic          chg_ov_ff;
	logic          nxt_chg_ov;
	logic [1:0]    ctrl_ff;
	logic [6:0]    event_ff;
	logic [6:0]    nxt_event;
	logic [6:0]    event_set;

	// Comparator decisions are two-flop synchronised before any use
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cmp_meta_ff <= '0;
			cs_ff       <= '0;
		end
		else
		begin
			cmp_meta_ff <= cmp;
			cs_ff       <= cmp_meta_ff;
		end
	end

	wire power_down_opt = ctrl_ff[`BPF_CTRL_PDN_BIT];
	wire zero_volt_ok   = ctrl_ff[`BPF_CTRL_ZV_BIT];
	wire in_normal      = (state_ff == BPF_NORMAL);

	wire oc_det_run    = in_normal && cs_ff.cell_over_charge;
	wire od_det_run    = in_normal && cs_ff.cell_under_discharge;
	wire short_det_run = in_normal && cs_ff.sense_over_short;
	wire doc_det_run   = in_normal && cs_ff.sense_over_discharge_current && !cs_ff.sense_over_short;
	wire coc_det_run   = in_normal && cs_ff.sense_under_charge_current;
	wire oc_rel_cond   = cs_ff.sense_over_discharge_current ? !cs_ff.cell_over_charge
	                                                        : cs_ff.cell_under_charge_release;
	wire oc_rel_run    = (state_ff == BPF_OVERCHARGE) && oc_rel_cond;
	wire od_rel_run    = (state_ff == BPF_OVERDISCHARGE) && !power_down_opt
	                     && !cs_ff.sense_charger_present && cs_ff.cell_over_discharge_release;
	wire doc_rel_run   = (state_ff == BPF_DSG_OC) && cs_ff.sense_near_ground;
	wire coc_rel_run   = (state_ff == BPF_CHG_OC) && !cs_ff.sense_under_charge_current;
	wire charger_wake  = cs_ff.sense_charger_present && !cs_ff.cell_under_discharge;
	wire zero_volt_blk = !zero_volt_ok && cs_ff.cell_at_zero_volt;

	wire oc_det_done;
	wire od_det_done;
	wire short_det_done;
	wire doc_det_done;
	wire coc_det_done;
	wire oc_rel_done;
	wire od_rel_done;
	wire doc_rel_done;
	wire coc_rel_done;

	bpf_delay_timer #(.LIMIT(OC_DET_CYC)) u_oc_det
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (oc_det_run),
		.expired (oc_det_done)
	);
	bpf_delay_timer #(.LIMIT(OD_DET_CYC)) u_od_det
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (od_det_run),
		.expired (od_det_done)
	);
	bpf_delay_timer #(.LIMIT(SHORT_DET_CYC)) u_short_det
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (short_det_run),
		.expired (short_det_done)
	);
	bpf_delay_timer #(.LIMIT(DOC_DET_CYC)) u_doc_det
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (doc_det_run),
		.expired (doc_det_done)
	);
	bpf_delay_timer #(.LIMIT(COC_DET_CYC)) u_coc_det
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (coc_det_run),
		.expired (coc_det_done)
	);
	bpf_delay_timer #(.LIMIT(RELEASE_CYC)) u_oc_rel
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (oc_rel_run),
		.expired (oc_rel_done)
	);
	bpf_delay_timer #(.LIMIT(RELEASE_CYC)) u_od_rel
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (od_rel_run),
		.expired (od_rel_done)
	);
	bpf_delay_timer #(.LIMIT(RELEASE_CYC)) u_doc_rel
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (doc_rel_run),
		.expired (doc_rel_done)
	);
	bpf_delay_timer #(.LIMIT(RELEASE_CYC)) u_coc_rel
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (coc_rel_run),
		.expired (coc_rel_done)
	);

	// Protection state; short outranks discharge overcurrent, then overcharge, then charge overcurrent, then overdischarge
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			BPF_NORMAL:
			begin
				if (short_det_done)
					nxt_state = BPF_DSG_OC;
				else if (doc_det_done)
					nxt_state = BPF_DSG_OC;
				else if (oc_det_done)
					nxt_state = BPF_OVERCHARGE;
				else if (coc_det_done)
					nxt_state = BPF_CHG_OC;
				else if (od_det_done)
					nxt_state = BPF_OVERDISCHARGE;
			end
			BPF_OVERCHARGE:
			begin
				if (oc_rel_done)
					nxt_state = BPF_NORMAL;
			end
			BPF_OVERDISCHARGE:
			begin
				if (charger_wake)
					nxt_state = BPF_NORMAL;
				else if (power_down_opt)
					nxt_state = BPF_SLEEP;
				else if (od_rel_done)
					nxt_state = BPF_NORMAL;
			end
			BPF_SLEEP:
			begin
				if (charger_wake)
					nxt_state = BPF_NORMAL;
			end
			BPF_DSG_OC:
			begin
				if (doc_rel_done)
					nxt_state = BPF_NORMAL;
			end
			BPF_CHG_OC:
			begin
				if (coc_rel_done)
					nxt_state = BPF_NORMAL;
			end
			default:
				nxt_state = BPF_NORMAL;
		endcase
	end

	// Charger overvoltage latch, no qualifying delay; detect wins over release
	assign nxt_chg_ov = cs_ff.charger_over_voltage ? 1'b1 :
	                    cs_ff.charger_under_release ? 1'b0 : chg_ov_ff;

	always_comb
	begin
		nxt_drive.chg_switch_en = (nxt_state != BPF_OVERCHARGE) && (nxt_state != BPF_CHG_OC)
		                          && !nxt_chg_ov && !zero_volt_blk;
		nxt_drive.dsg_switch_en = (nxt_state == BPF_NORMAL) || (nxt_state == BPF_OVERCHARGE)
		                          || (nxt_state == BPF_CHG_OC);
		nxt_drive.sense_pullup_resistor_en = (nxt_state == BPF_OVERDISCHARGE)
		                                     || (nxt_state == BPF_SLEEP);
		nxt_drive.sense_pulldown_resistor_en = (nxt_state == BPF_DSG_OC);
		nxt_drive.sleep = (nxt_state == BPF_SLEEP);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff  <= BPF_NORMAL;
			drive_ff  <= '0;
			chg_ov_ff <= 1'b0;
		end
		else
		begin
			state_ff  <= nxt_state;
			drive_ff  <= nxt_drive;
			chg_ov_ff <= nxt_chg_ov;
		end
	end

	assign drive = drive_ff;

	// Sticky event bits, raised on entry to each status
	wire entering = (nxt_state != state_ff);
	assign event_set[`BPF_EV_OVERCHARGE]    = entering && (nxt_state == BPF_OVERCHARGE);
	assign event_set[`BPF_EV_OVERDISCHARGE] = entering && (nxt_state == BPF_OVERDISCHARGE);
	assign event_set[`BPF_EV_DSG_OC]        = entering && (nxt_state == BPF_DSG_OC) && !short_det_done;
	assign event_set[`BPF_EV_SHORT]         = entering && (nxt_state == BPF_DSG_OC) && short_det_done;
	assign event_set[`BPF_EV_CHG_OC]        = entering && (nxt_state == BPF_CHG_OC);
	assign event_set[`BPF_EV_CHG_OV]        = nxt_chg_ov && !chg_ov_ff;
	assign event_set[`BPF_EV_SLEEP]         = entering && (nxt_state == BPF_SLEEP);

	// AXI4-Lite slave: address and data are taken independently, then written together
	logic        aw_held_ff;
	logic        w_held_ff;
	logic [7:0]  waddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        awready_ff;
	logic        wready_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        arready_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;

	wire aw_fire  = awvalid && awready_ff;
	wire w_fire   = wvalid && wready_ff;
	wire wr_fire  = aw_held_ff && w_held_ff && !bvalid_ff;
	wire b_done   = bvalid_ff && bready;
	wire ar_fire  = arvalid && arready_ff;
	wire r_done   = rvalid_ff && rready;
	wire nxt_aw_held = wr_fire ? 1'b0 : (aw_held_ff || aw_fire);
	wire nxt_w_held  = wr_fire ? 1'b0 : (w_held_ff || w_fire);
	wire nxt_bvalid  = wr_fire || (bvalid_ff && !bready);
	wire nxt_rvalid  = ar_fire || (rvalid_ff && !rready);

	wire wr_ctrl   = wr_fire && (waddr_ff == `BPF_CTRL_OFS);
	wire wr_event  = wr_fire && (waddr_ff == `BPF_EVENT_OFS);
	wire wr_mapped = wr_ctrl || wr_event || (waddr_ff == `BPF_STATUS_OFS);
	wire [6:0] ev_clear = (wr_event && wstrb_ff[0]) ? wdata_ff[6:0] : 7'h00;
	assign nxt_event = (event_ff & ~ev_clear) | event_set;

	wire [7:0] raddr = araddr[7:0];
	wire [31:0] status_word = {22'h000000, chg_ov_ff, drive_ff, 1'b0, state_ff};
	wire rd_ctrl   = (araddr[31:8] == 24'h000000) && (raddr == `BPF_CTRL_OFS);
	wire rd_status = (araddr[31:8] == 24'h000000) && (raddr == `BPF_STATUS_OFS);
	wire rd_event  = (araddr[31:8] == 24'h000000) && (raddr == `BPF_EVENT_OFS);
	wire [31:0] rd_mux = rd_ctrl   ? {30'h00000000, ctrl_ff} :
	                     rd_status ? status_word :
	                     rd_event  ? {25'h0000000, event_ff} : 32'h00000000;
	wire rd_ok = rd_ctrl || rd_status || rd_event;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
		end
		else
		begin
			aw_held_ff <= nxt_aw_held;
			w_held_ff  <= nxt_w_held;
			awready_ff <= !nxt_aw_held;
			wready_ff  <= !nxt_w_held;
			bvalid_ff  <= nxt_bvalid;
			arready_ff <= !nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			waddr_ff <= 8'h00;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
			bresp_ff <= `BPF_RESP_OKAY;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `BPF_RESP_OKAY;
		end
		else
		begin
			if (aw_fire)
				waddr_ff <= (awaddr[31:8] == 24'h000000) ? awaddr[7:0] : 8'hff;
			if (w_fire)
			begin
				wdata_ff <= wdata;
				wstrb_ff <= wstrb;
			end
			if (wr_fire)
				bresp_ff <= wr_mapped ? `BPF_RESP_OKAY : `BPF_RESP_SLVERR;
			if (ar_fire)
			begin
				rdata_ff <= rd_mux;
				rresp_ff <= rd_ok ? `BPF_RESP_OKAY : `BPF_RESP_SLVERR;
			end
		end
	end

	// Option bits and sticky events; a new event wins over a clear in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_ff  <= `BPF_CTRL_RESET;
			event_ff <= `BPF_EVENT_RESET;
		end
		else
		begin
			if (wr_ctrl && wstrb_ff[0])
				ctrl_ff <= wdata_ff[1:0];
			event_ff <= nxt_event;
		end
	end

	assign awready = awready_ff;
	assign wready  = wready_ff;
	assign bvalid  = bvalid_ff;
	assign bresp   = bresp_ff;
	assign arready = arready_ff;
	assign rvalid  = rvalid_ff;
	assign rdata   = rdata_ff;
	assign rresp   = rresp_ff;
endmodule

// file: sim/bpf_analog_model.sv
module bpf_analog_model
	import bpf_pkg::*;
#(
	parameter logic signed [15:0] OC_MV  = 16'sh109a,
	parameter logic signed [15:0] CR_MV  = 16'sh0fd2,
	parameter logic signed [15:0] OD_MV  = 16'sh0af0,
	parameter logic signed [15:0] DU_MV  = 16'sh0bb8,
	parameter logic signed [15:0] DOC_MV = 16'sh0064,
	parameter logic signed [15:0] SH_MV  = 16'sh012c,
	parameter logic signed [15:0] COC_MV = -16'sh0064,
	parameter logic signed [15:0] GND_MV = 16'sh0014,
	parameter logic signed [15:0] ZV_MV  = 16'sh0190,
	parameter logic signed [15:0] CHG_MV = -16'sh02bc,
	parameter logic signed [15:0] OVD_MV = 16'sh1f40,
	parameter logic signed [15:0] OVR_MV = 16'sh1c84
)
(
	input  wire logic signed [15:0] cell_mv,
	input  wire logic signed [15:0] sense_mv,
	output wire bpf_cmp_type        cmp
);
	timeunit 1ns;
	timeprecision 1ns;
	// Charger voltage is read between the cell supply and the sense pin
	wire logic signed [15:0] chgr_mv = cell_mv - sense_mv;
	assign cmp.cell_over_charge = cell_mv > OC_MV;
	assign cmp.cell_under_charge_release = cell_mv < CR_MV;
	assign cmp.cell_under_discharge = cell_mv < OD_MV;
	assign cmp.cell_over_discharge_release = cell_mv >= DU_MV;
	assign cmp.sense_over_discharge_current = sense_mv >= DOC_MV;
	assign cmp.sense_over_short = sense_mv >= SH_MV;
	assign cmp.sense_under_charge_current = sense_mv <= COC_MV;
	assign cmp.sense_charger_present = sense_mv < CHG_MV;
	assign cmp.sense_near_ground = (sense_mv < GND_MV) && (sense_mv > -GND_MV);
	assign cmp.charger_over_voltage = chgr_mv > OVD_MV;
	assign cmp.charger_under_release = chgr_mv < OVR_MV;
	assign cmp.cell_at_zero_volt = cell_mv < ZV_MV;
endmodule

// file: sim/bpf_protect_properties.sv
module bpf_protect_chk
	import bpf_pkg::*;
#(
	parameter int unsigned OC_DET_CYC    = 40,
	parameter int unsigned SHORT_DET_CYC = 10
)
(
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire bpf_cmp_type   cmp,
	input wire bpf_drive_type drive,
	input wire logic          awvalid,
	input wire logic          awready,
	input wire logic          wvalid,
	input wire logic          wready,
	input wire logic [1:0]    bresp,
	input wire logic          bvalid,
	input wire logic          bready,
	input wire logic          arvalid,
	input wire logic          arready,
	input wire logic [31:0]   rdata,
	input wire logic          rvalid,
	input wire logic          rready
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0] sc_ff;
	logic [7:0] oc_ff;
	wire on = drive.chg_switch_en && drive.dsg_switch_en;
	// Length of a pending fault while both switches are still on
	always_ff @(posedge aclk)
	begin
		sc_ff <= (aresetn && on && cmp.sense_over_short) ? sc_ff + 8'h01 : 8'h00;
		oc_ff <= (aresetn && on && cmp.cell_over_charge) ? oc_ff + 8'h01 : 8'h00;
	end
	sequence s_wr_take;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rd_take;
		arvalid && arready;
	endsequence
	a_wr_answer: assert property (s_wr_take |-> ##[1:2] bvalid)
		else $error("write not answered");
	a_rd_answer: assert property (s_rd_take |-> ##[1:2] rvalid)
		else $error("read not answered");
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	a_ov_cut: assert property (cmp.charger_over_voltage [*4] |-> !drive.chg_switch_en)
		else $error("charger overvoltage left charge on");
	a_pd_alone: assert property (drive.sense_pulldown_resistor_en |->
		!drive.dsg_switch_en && !drive.sense_pullup_resistor_en)
		else $error("pull-down with wrong companions");
	a_pu_alone: assert property (drive.sense_pullup_resistor_en |->
		!drive.dsg_switch_en && !drive.sense_pulldown_resistor_en)
		else $error("pull-up with wrong companions");
	a_sleep_pu: assert property (drive.sleep |-> drive.sense_pullup_resistor_en)
		else $error("sleep without pull-up");
	a_norm_open: assert property (on |-> !drive.sense_pullup_resistor_en &&
		!drive.sense_pulldown_resistor_en)
		else $error("resistor connected in normal");
	a_short_time: assert property (sc_ff <= SHORT_DET_CYC + 4)
		else $error("short not cut in time");
	a_oc_time: assert property (oc_ff <= OC_DET_CYC + 4)
		else $error("overcharge not cut in time");
endmodule

bind bpf_protect bpf_protect_chk #(.OC_DET_CYC(OC_DET_CYC), .SHORT_DET_CYC(SHORT_DET_CYC)) chk_u
(
	.aclk(aclk), .aresetn(aresetn), .cmp(cmp), .drive(drive), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rvalid(rvalid), .rready(rready)
);

// file: sim/bpf_protect_test.sv
module bpf_protect_test
	import bpf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LOC = 40, LOD = 30, LDOC = 20, LCOC = 20, LSH = 10, LREL = 8;
	localparam logic signed [15:0] NOM = 16'sh0e74, HI = 16'sh1130, MID = 16'sh1036;
	localparam logic signed [15:0] LO = 16'sh09c4, GAP = 16'sh0b54, S0 = 16'sh0000;
	localparam logic signed [15:0] SDOC = 16'sh00c8, SSH = 16'sh01f4, SCOC = -16'sh012c;
	localparam logic signed [15:0] SCHG = -16'sh03e8, SOV = -16'sh1388, SOVR = -16'sh0bb8;
	logic               aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic               arvalid, arready, rvalid, rready;
	logic [31:0]        awaddr, wdata, araddr, rdata;
	logic [3:0]         wstrb;
	logic [1:0]         bresp, rresp;
	logic signed [15:0] cell_mv, sense_mv;
	bpf_cmp_type        cmp;
	bpf_drive_type      drive;
	int                 fails, compares;
	logic               slow_ready;

	bpf_analog_model ana_u (.cell_mv(cell_mv), .sense_mv(sense_mv), .cmp(cmp));
	bpf_protect #(.OC_DET_CYC(LOC), .OD_DET_CYC(LOD), .DOC_DET_CYC(LDOC),
		.COC_DET_CYC(LCOC), .SHORT_DET_CYC(LSH), .RELEASE_CYC(LREL)) dut_u
	(
		.aclk(aclk), .aresetn(aresetn), .cmp(cmp), .drive(drive), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready)
	);

	task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", w, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic an(input logic signed [15:0] c, input logic signed [15:0] s);
		cell_mv <= c;
		sense_mv <= s;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= !slow_ready;
		forever
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && bready)
			begin
				chk("bresp", {30'h0, bresp}, {30'h0, er});
				bready <= 1'b0;
				break;
			end
			// Late ready leaves the response standing one extra cycle
			if (bvalid) bready <= 1'b1;
		end
	endtask
	task automatic rd(input string w, input logic [31:0] a, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= !slow_ready;
		forever
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid && rready)
			begin
				chk(w, rdata, e);
				chk("rresp", {30'h0, rresp}, {30'h0, er});
				rready <= 1'b0;
				break;
			end
			if (rvalid) rready <= 1'b1;
		end
	endtask
	task automatic dchk(input string w, input logic [4:0] e);
		chk(w, {27'h0, drive}, {27'h0, e});
	endtask
	// Drive pins and the status word must agree on state and outputs
	task automatic sts(input bpf_state_type s, input logic [4:0] e, input logic ov);
		dchk("drive", e);
		rd("status", 32'h04, {22'h0, ov, e, 1'b0, s}, 2'h0);
	endtask

	task automatic t_regs;
		rd("ctrl", 32'h00, 32'h0, 2'h0);
		sts(BPF_NORMAL, 5'h03, 1'b0);
		slow_ready = 1'b1;
		rd("unmapped", 32'h0c, 32'h0, 2'h2);
		wr(32'h0c, 32'h1, 2'h2);
		slow_ready = 1'b0;
		wr(32'h04, 32'hff, 2'h0);
		sts(BPF_NORMAL, 5'h03, 1'b0);
		$display("test regs done");
	endtask
	task automatic t_oc;
		an(HI, S0);
		cyc(LOC - 2);
		an(NOM, S0);
		cyc(3);
		an(HI, S0);
		cyc(LOC - 2);
		dchk("oc_restart", 5'h03);
		cyc(10);
		sts(BPF_OVERCHARGE, 5'h02, 1'b0);
		rd("ev_oc", 32'h08, 32'h1, 2'h0);
		wr(32'h08, 32'h1, 2'h0);
		rd("ev_clr", 32'h08, 32'h0, 2'h0);
		an(MID, S0);
		cyc(16);
		dchk("oc_hold", 5'h02);
		an(NOM, S0);
		cyc(16);
		dchk("oc_rel", 5'h03);
		an(HI, S0);
		cyc(LOC + 8);
		an(MID, SDOC);
		cyc(16);
		dchk("oc_rel_load", 5'h03);
		an(NOM, S0);
		cyc(16);
		$display("test overcharge done");
	endtask
	task automatic t_od;
		an(LO, S0);
		cyc(LOD - 2);
		dchk("od_early", 5'h03);
		cyc(10);
		sts(BPF_OVERDISCHARGE, 5'h05, 1'b0);
		an(GAP, S0);
		cyc(16);
		dchk("od_gap", 5'h05);
		an(NOM, S0);
		cyc(LREL - 4);
		dchk("od_wait", 5'h05);
		cyc(10);
		dchk("od_wake", 5'h03);
		$display("test overdischarge done");
	endtask
	task automatic t_pd;
		wr(32'h00, 32'h1, 2'h0);
		an(LO, S0);
		cyc(LOD + 8);
		sts(BPF_SLEEP, 5'h15, 1'b0);
		rd("ev_pd", 32'h08, 32'h43, 2'h0);
		an(NOM, S0);
		cyc(16);
		dchk("pd_stay", 5'h15);
		an(NOM, SCHG);
		cyc(5);
		dchk("pd_wake", 5'h03);
		an(NOM, S0);
		wr(32'h00, 32'h0, 2'h0);
		$display("test power-down done");
	endtask
	task automatic t_dsg;
		for (int i = 0; i < 2; i++)
		begin
			wr(32'h08, 32'h7f, 2'h0);
			an(NOM, i ? SSH : SDOC);
			cyc((i ? LSH : LDOC) - 2);
			dchk("doc_early", 5'h03);
			cyc(10);
			sts(BPF_DSG_OC, 5'h09, 1'b0);
			rd("ev_doc", 32'h08, i ? 32'h8 : 32'h4, 2'h0);
			an(NOM, S0);
			cyc(16);
			dchk("doc_rel", 5'h03);
		end
		$display("test discharge overcurrent done");
	endtask
	task automatic t_coc;
		an(NOM, SCOC);
		cyc(LCOC - 2);
		dchk("coc_early", 5'h03);
		cyc(10);
		sts(BPF_CHG_OC, 5'h02, 1'b0);
		an(NOM, S0);
		cyc(16);
		dchk("coc_rel", 5'h03);
		$display("test charge overcurrent done");
	endtask
	task automatic t_ov;
		an(NOM, SOV);
		cyc(4);
		sts(BPF_NORMAL, 5'h02, 1'b1);
		an(NOM, SOVR);
		cyc(4);
		dchk("ov_back", 5'h03);
		an(NOM, S0);
		rd("ev_ov", 32'h08, 32'h38, 2'h0);
		cyc(16);
		$display("test charger overvoltage done");
	endtask
	task automatic t_zv;
		an(S0, S0);
		cyc(4);
		dchk("zv_block", 5'h02);
		wr(32'h00, 32'h2, 2'h0);
		cyc(3);
		dchk("zv_allow", 5'h03);
		an(NOM, S0);
		wr(32'h00, 32'h0, 2'h0);
		cyc(16);
		$display("test zero volt done");
	endtask
	task automatic tally_and_finish;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	initial
	begin
		repeat (6000) @(posedge aclk);
		fails++;
		tally_and_finish;
	end
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, wdata, araddr} = 96'h0;
		wstrb = 4'hf;
		slow_ready = 1'b0;
		cell_mv = NOM;
		sense_mv = S0;
		cyc(2);
		aresetn <= 1'b1;
		cyc(2);
		t_regs;
		t_oc;
		t_od;
		t_pd;
		t_dsg;
		t_coc;
		t_ov;
		t_zv;
		tally_and_finish;
	end
endmodule
